/* File: design/tpsi_pkg.sv */
// constants, field layout and state type of the two-profile step indexer
// Overview of operation
// - two independent stored motion profiles
// - base speed accepted from 1 to 5000
// - max speed accepted from 1 to 50000
// - accel 100 to 9999999, higher ramps faster
// - step count 0 to 8388607, exact pulses
// - one rate for acceleration and deceleration
// - pulse train starts and ends at base
// - ramp up, hold, ramp down, complete
// - soft limit decelerates, finishes at base
// - hard limit stops pulses, asserts complete
// - profile input loads profile and starts index
// - profiles retained, programmed before first index
// - direction pin low means counterclockwise
// - software start uses software direction
// - complete output held programmed microseconds
// - axis address up to 99, default zero
// - axis address written and read back
// - inputs active low, open reads inactive
// - on/off input active removes phase power
// - current reduced while indexer not running
package tpsi_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned NS_PER_US = 1000;
   localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int unsigned CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

   localparam int unsigned ACC_W = 24;
   localparam int unsigned SPD_W = 16;
   localparam int unsigned CNT_W = 23;
   localparam int unsigned CT_W = 10;
   localparam int unsigned AX_W = 7;
   localparam int unsigned TMR_W = 15;
   localparam int unsigned ADDR_W = 8;

   localparam logic [ACC_W-1:0] ACCEL_MIN = 24'd100;
   localparam logic [ACC_W-1:0] ACCEL_MAX = 24'd9999999;
   localparam logic [SPD_W-1:0] BASE_MIN = 16'd1;
   localparam logic [SPD_W-1:0] BASE_MAX = 16'd5000;
   localparam logic [SPD_W-1:0] MAXSPD_MIN = 16'd1;
   localparam logic [SPD_W-1:0] MAXSPD_MAX = 16'd50000;
   localparam logic [CT_W-1:0] CTIME_MIN = 10'd1;
   localparam logic [CT_W-1:0] CTIME_MAX = 10'd1000;
   localparam logic [AX_W-1:0] AXIS_MAX = 7'd99;

   localparam logic [ACC_W-1:0] RST_ACCEL = 24'd100;
   localparam logic [SPD_W-1:0] RST_BASE = 16'd1;
   localparam logic [SPD_W-1:0] RST_MAXSPD = 16'd1;
   localparam logic [CNT_W-1:0] RST_COUNT = 23'd0;
   localparam logic [CT_W-1:0] RST_CTIME = 10'd1;
   localparam logic [AX_W-1:0] RST_AXIS = 7'd0;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_AXIS = 8'h08;
   localparam logic [2:0] PROF0_SEL = 3'h1;
   localparam logic [2:0] PROF1_SEL = 3'h2;
   localparam logic [2:0] F_ACCEL = 3'h0;
   localparam logic [2:0] F_BASE = 3'h1;
   localparam logic [2:0] F_MAXSPD = 3'h2;
   localparam logic [2:0] F_COUNT = 3'h3;
   localparam logic [2:0] F_CTIME = 3'h4;

   localparam int unsigned CB_GO = 0;
   localparam int unsigned CB_PSEL = 1;
   localparam int unsigned CB_SOFT = 2;
   localparam int unsigned CB_HARD = 3;
   localparam int unsigned CB_DIR = 4;
   localparam int unsigned SB_RUN = 0;
   localparam int unsigned SB_BUSY = 1;
   localparam int unsigned SB_COMP = 2;
   localparam int unsigned SB_DIR = 3;
   localparam int unsigned SB_SOFT = 4;
   localparam int unsigned SB_PIN = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_DONE = 2'h3
   } tpsi_state_t;
endpackage

/* File: design/tpsi_rate.sv */
// fractional rate accumulator: ticks rate times per second of clock
`timescale 1ns/100ps
`default_nettype none
module tpsi_rate #(
   parameter int unsigned W = 16
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clr,
   input wire logic [W-1:0] rate,
   output logic tick
);
   import tpsi_pkg::*;
   localparam logic [25:0] LIM = 26'(CLK_HZ);
   logic [25:0] acc;
   logic [25:0] sum;

   assign sum = acc + 26'(rate);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         acc <= 26'h0;
         tick <= 1'b0;
      end else if (clr) begin
         acc <= 26'h0;
         tick <= 1'b0;
      end else if (sum >= LIM) begin
         acc <= sum - LIM;
         tick <= 1'b1;
      end else begin
         acc <= sum;
         tick <= 1'b0;
      end
   end
endmodule // tpsi_rate
`default_nettype wire

/* File: design/tpsi_indexer.sv */
// two-profile step indexer with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
module tpsi_indexer (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [tpsi_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tpsi_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic prof1_b,
   input wire logic prof2_b,
   input wire logic dir_in_b,
   input wire logic onoff_b,
   input wire logic soft_lim_b,
   input wire logic hard_lim_b,
   input wire logic complete_in,
   output logic complete_o,
   output logic complete_oe,
   output logic step,
   output logic dir_ccw,
   output logic phase_en,
   output logic cur_reduce,
   output logic running
);
   import tpsi_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // stored profiles and software control

   logic [ACC_W-1:0] p_accel [2];
   logic [SPD_W-1:0] p_base [2];
   logic [SPD_W-1:0] p_max [2];
   logic [CNT_W-1:0] p_count [2];
   logic [CT_W-1:0] p_ctime [2];
   logic [AX_W-1:0] axis;
   logic sw_dir;
   logic sw_psel;
   logic go_pls;
   logic soft_pls;
   logic hard_pls;

   tpsi_state_t state;
   logic [CNT_W-1:0] rem;
   logic [SPD_W-1:0] spd;
   logic [ACC_W-1:0] a_accel;
   logic [SPD_W-1:0] a_base;
   logic [SPD_W-1:0] a_max;
   logic [CT_W-1:0] a_ctime;
   logic [TMR_W-1:0] ctimer;
   logic soft_on;
   logic src_sw;

   logic wr_go;
   logic wr_en;
   logic wr_ok;
   logic wr_prof;
   logic wr_pi;
   logic [2:0] wr_fld;
   logic [31:0] wd;
   logic rd_ok;
   logic [31:0] rd_val;

   assign wd = s_axi_wdata;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
      && !s_axi_bvalid;
   assign wr_en = s_axi_awready;
   assign wr_prof = (s_axi_awaddr[7:5] == PROF0_SEL)
      || (s_axi_awaddr[7:5] == PROF1_SEL);
   assign wr_pi = (s_axi_awaddr[7:5] == PROF1_SEL);
   assign wr_fld = s_axi_awaddr[4:2];

   // only full-word writes to mapped offsets are taken
   always_comb begin
      wr_ok = 1'b0;
      if (s_axi_wstrb == 4'hf && s_axi_awaddr[1:0] == 2'h0) begin
         if (wr_prof) begin
            wr_ok = (wr_fld <= F_CTIME);
         end else begin
            wr_ok = (s_axi_awaddr == ADDR_CTRL)
               || (s_axi_awaddr == ADDR_AXIS);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // out-of-range values are dropped and the old value kept
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 2; i++) begin
            p_accel[i] <= RST_ACCEL;
            p_base[i] <= RST_BASE;
            p_max[i] <= RST_MAXSPD;
            p_count[i] <= RST_COUNT;
            p_ctime[i] <= RST_CTIME;
         end
      end else if (wr_en && wr_ok && wr_prof) begin
         unique case (wr_fld)
            F_ACCEL: begin
               if (wd >= 32'(ACCEL_MIN) && wd <= 32'(ACCEL_MAX))
                  p_accel[wr_pi] <= wd[ACC_W-1:0];
            end
            F_BASE: begin
               if (wd >= 32'(BASE_MIN) && wd <= 32'(BASE_MAX))
                  p_base[wr_pi] <= wd[SPD_W-1:0];
            end
            F_MAXSPD: begin
               if (wd >= 32'(MAXSPD_MIN) && wd <= 32'(MAXSPD_MAX))
                  p_max[wr_pi] <= wd[SPD_W-1:0];
            end
            F_COUNT: begin
               if (wd[31:CNT_W] == '0)
                  p_count[wr_pi] <= wd[CNT_W-1:0];
            end
            default: begin
               if (wd >= 32'(CTIME_MIN) && wd <= 32'(CTIME_MAX))
                  p_ctime[wr_pi] <= wd[CT_W-1:0];
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         axis <= RST_AXIS;
      end else if (wr_en && wr_ok && s_axi_awaddr == ADDR_AXIS
                   && wd <= 32'(AXIS_MAX)) begin
         axis <= wd[AX_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sw_dir <= 1'b0;
         sw_psel <= 1'b0;
         go_pls <= 1'b0;
         soft_pls <= 1'b0;
         hard_pls <= 1'b0;
      end else begin
         go_pls <= 1'b0;
         soft_pls <= 1'b0;
         hard_pls <= 1'b0;
         if (wr_en && wr_ok && s_axi_awaddr == ADDR_CTRL) begin
            // direction is settable only while idle
            if (state == ST_IDLE)
               sw_dir <= wd[CB_DIR];
            sw_psel <= wd[CB_PSEL];
            go_pls <= wd[CB_GO];
            soft_pls <= wd[CB_SOFT];
            hard_pls <= wd[CB_HARD];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read side

   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (s_axi_araddr[1:0] != 2'h0) begin
         rd_ok = 1'b0;
      end else if (s_axi_araddr[7:5] == PROF0_SEL
                   || s_axi_araddr[7:5] == PROF1_SEL) begin
         unique case (s_axi_araddr[4:2])
            F_ACCEL: rd_val = 32'(p_accel[s_axi_araddr[6]]);
            F_BASE: rd_val = 32'(p_base[s_axi_araddr[6]]);
            F_MAXSPD: rd_val = 32'(p_max[s_axi_araddr[6]]);
            F_COUNT: rd_val = 32'(p_count[s_axi_araddr[6]]);
            F_CTIME: rd_val = 32'(p_ctime[s_axi_araddr[6]]);
            default: rd_ok = 1'b0;
         endcase
      end else if (s_axi_araddr == ADDR_CTRL) begin
         rd_val[CB_PSEL] = sw_psel;
         rd_val[CB_DIR] = sw_dir;
      end else if (s_axi_araddr == ADDR_STAT) begin
         rd_val[SB_RUN] = running;
         rd_val[SB_BUSY] = (state != ST_IDLE);
         rd_val[SB_COMP] = complete_oe;
         rd_val[SB_DIR] = dir_ccw;
         rd_val[SB_SOFT] = soft_on;
         rd_val[SB_PIN] = complete_in;
      end else if (s_axi_araddr == ADDR_AXIS) begin
         rd_val = 32'(axis);
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin requests

   logic p1_q;
   logic p2_q;
   logic dir_q;
   logic p1_rise;
   logic p2_rise;
   logic pin_start;
   logic start;
   logic sel;
   logic soft_req;
   logic hard_req;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         p1_q <= !prof1_b;
         p2_q <= !prof2_b;
         dir_q <= !dir_in_b;
      end
   end

   assign p1_rise = !prof1_b && !p1_q;
   assign p2_rise = !prof2_b && !p2_q;
   assign pin_start = p1_rise || p2_rise;
   // starts only count when idle
   assign start = (state == ST_IDLE) && (pin_start || go_pls);
   // profile one wins if both inputs rise together
   assign sel = pin_start ? !p1_rise : sw_psel;
   assign soft_req = soft_pls || !soft_lim_b;
   assign hard_req = hard_pls || !hard_lim_b;

   ////////////////////////////////////////////////////////////////////////
   // motion

   logic step_tick;
   logic ramp_tick;
   logic run;
   logic decel;
   logic [47:0] need;
   logic [31:0] have;

   assign run = (state == ST_RUN);
   // steps left to brake versus (v^2 - base^2) / 2a
   assign need = {24'h0, rem, 1'b0} * {24'h0, a_accel};
   assign have = 32'(spd) * 32'(spd) - 32'(a_base) * 32'(a_base);
   assign decel = soft_on || (need <= 48'(have));

   tpsi_rate #(.W(SPD_W)) u_step_rate (
      .clock(clock),
      .rst_b(rst_b),
      .clr(!run),
      .rate(spd),
      .tick(step_tick)
   );

   // ramp waits for the first step so the first period is at base speed
   tpsi_rate #(.W(ACC_W)) u_ramp_rate (
      .clock(clock),
      .rst_b(rst_b),
      .clr(!run || !running),
      .rate(a_accel),
      .tick(ramp_tick)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         rem <= '0;
         ctimer <= '0;
         complete_oe <= 1'b0;
         step <= 1'b0;
         running <= 1'b0;
      end else begin
         step <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  rem <= p_count[sel];
                  if (p_count[sel] == '0) begin
                     state <= ST_DONE;
                  end else begin
                     state <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (hard_req) begin
                  state <= ST_DONE;
                  running <= 1'b0;
               end else if (step_tick) begin
                  step <= 1'b1;
                  running <= 1'b1;
                  rem <= rem - 1'b1;
                  if (rem == CNT_W'(1)) begin
                     state <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               running <= 1'b0;
               // completion follows the last pulse by one clock
               if (!complete_oe) begin
                  complete_oe <= 1'b1;
                  ctimer <= TMR_W'(a_ctime) * TMR_W'(CYC_PER_US);
               end else if (ctimer <= TMR_W'(1)) begin
                  state <= ST_IDLE;
                  complete_oe <= 1'b0;
               end else begin
                  ctimer <= ctimer - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         spd <= RST_BASE;
         a_accel <= RST_ACCEL;
         a_base <= RST_BASE;
         a_max <= RST_MAXSPD;
         a_ctime <= RST_CTIME;
         soft_on <= 1'b0;
      end else if (start) begin
         spd <= p_base[sel];
         a_accel <= p_accel[sel];
         a_base <= p_base[sel];
         a_max <= p_max[sel];
         a_ctime <= p_ctime[sel];
         soft_on <= 1'b0;
      end else if (run) begin
         if (soft_req)
            soft_on <= 1'b1;
         if (ramp_tick) begin
            // one shared rate for both ramps
            if (decel) begin
               if (spd > a_base)
                  spd <= spd - 1'b1;
            end else if (spd < a_max) begin
               spd <= spd + 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // direction and driver outputs

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         src_sw <= 1'b0;
         dir_ccw <= 1'b0;
      end else begin
         if (start && !pin_start)
            src_sw <= 1'b1;
         else if (start || (state == ST_IDLE && dir_q != !dir_in_b))
            src_sw <= 1'b0;
         if (start && !pin_start)
            dir_ccw <= sw_dir;
         else if (start || !src_sw)
            dir_ccw <= !dir_in_b;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_en <= 1'b0;
         cur_reduce <= 1'b1;
         complete_o <= 1'b0;
      end else begin
         phase_en <= onoff_b;
         cur_reduce <= !run;
         complete_o <= 1'b0;
      end
   end

endmodule // tpsi_indexer
`default_nettype wire

/* File: testbench/tpsi_indexer_checker.sv */
// port-level assertions for the two-profile step indexer
`timescale 1ns/100ps
`default_nettype none
module tpsi_indexer_checker (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic onoff_b,
   input wire logic hard_lim_b,
   input wire logic complete_o,
   input wire logic complete_oe,
   input wire logic step,
   input wire logic dir_ccw,
   input wire logic phase_en,
   input wire logic cur_reduce,
   input wire logic running
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   a_step_single: assert property (step |=> !step)
      else $error("step pulse wider than one clock");
   a_no_step_done: assert property (complete_oe |-> !step)
      else $error("step during completion");
   a_done_stops_run: assert property ($rose(complete_oe) |-> !running)
      else $error("running left high at completion");
   a_run_full_cur: assert property (running |-> !cur_reduce)
      else $error("current reduced while running");
   a_done_reduced: assert property (complete_oe |-> cur_reduce)
      else $error("current not reduced at completion");
   a_drain_low: assert property (complete_oe |-> !complete_o)
      else $error("complete output not sinking");
   a_hard_halt: assert property (running && !hard_lim_b |=> !step)
      else $error("step after hard limit");
   a_hard_done: assert property (
      running && !hard_lim_b |-> ##[1:2] complete_oe)
      else $error("no completion after hard limit");
   a_phase_follow: assert property (
      $past(rst_b) |-> phase_en == !$past(!onoff_b))
      else $error("phase enable does not follow on/off input");
   a_dir_hold_run: assert property (
      running && $past(running) |-> $stable(dir_ccw))
      else $error("direction changed during index");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read response missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   c_step: cover property (step);
   c_done: cover property ($rose(complete_oe));
   c_hard: cover property (running && !hard_lim_b);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // tpsi_indexer_checker
bind tpsi_indexer tpsi_indexer_checker u_chk (.*);
`default_nettype wire

/* File: testbench/tpsi_plc_model.sv */
// controller pins and complete-line pull-up facing the indexer
`timescale 1ns/100ps
`default_nettype none
module tpsi_plc_model (
   input wire logic clock,
   input wire logic complete_o,
   input wire logic complete_oe,
   output logic complete_in,
   output var logic prof1_b,
   output var logic prof2_b,
   output var logic dir_in_b,
   output var logic onoff_b,
   output var logic soft_lim_b,
   output var logic hard_lim_b
);
   // open inputs rest at the pulled-up inactive level
   initial begin
      prof1_b = 1'b1;
      prof2_b = 1'b1;
      dir_in_b = 1'b1;
      onoff_b = 1'b1;
      soft_lim_b = 1'b1;
      hard_lim_b = 1'b1;
   end
   assign complete_in = complete_oe ? complete_o : 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   // only one profile pin is ever pulled low
   task automatic press(input int which);
      @(posedge clock);
      if (which == 1) begin
         prof1_b <= 1'b0;
      end else begin
         prof2_b <= 1'b0;
      end
      repeat (3) @(posedge clock);
      prof1_b <= 1'b1;
      prof2_b <= 1'b1;
   endtask
   task automatic set_pin(input int which, input logic lvl);
      @(posedge clock);
      case (which)
         0: dir_in_b <= lvl;
         1: onoff_b <= lvl;
         2: soft_lim_b <= lvl;
         default: hard_lim_b <= lvl;
      endcase
      repeat (2) @(posedge clock);
   endtask
endmodule // tpsi_plc_model
`default_nettype wire

/* File: testbench/test_two_profile_step_indexer.sv */
// self-checking bench for the two-profile step indexer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module test_two_profile_step_indexer;
   import tpsi_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic prof1_b, prof2_b, dir_in_b, onoff_b, soft_lim_b, hard_lim_b;
   logic complete_in, complete_o, complete_oe, step, dir_ccw, phase_en;
   logic cur_reduce, running;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int step_cnt = 0;
   int last_t = 0;
   int prev_t = 0;
   tpsi_indexer dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rresp(rresp),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .prof1_b(prof1_b), .prof2_b(prof2_b),
      .dir_in_b(dir_in_b), .onoff_b(onoff_b), .soft_lim_b(soft_lim_b),
      .hard_lim_b(hard_lim_b), .complete_in(complete_in),
      .complete_o(complete_o), .complete_oe(complete_oe), .step(step),
      .dir_ccw(dir_ccw), .phase_en(phase_en), .cur_reduce(cur_reduce),
      .running(running));
   tpsi_plc_model u_plc (.clock(clock), .complete_o(complete_o),
      .complete_oe(complete_oe), .complete_in(complete_in),
      .prof1_b(prof1_b), .prof2_b(prof2_b), .dir_in_b(dir_in_b),
      .onoff_b(onoff_b), .soft_lim_b(soft_lim_b), .hard_lim_b(hard_lim_b));
   always #(CLK_PERIOD_NS / 2) clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (step === 1'b1) begin
         step_cnt <= step_cnt + 1;
         prev_t <= last_t;
         last_t <= cyc;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input int d, input logic [1:0] er);
      @(posedge clock);
      awaddr <= a;
      wdata <= 32'(d);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("write response", er, bresp)
   endtask
   task automatic rd(input logic [7:0] a, input int ed, input logic [1:0] er);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK("read response", er, rresp)
      `CHK("read data", 32'(ed), rdata)
   endtask
   task automatic wait_steps(input int n);
      while (step_cnt < n) begin
         @(posedge clock);
      end
   endtask
   task automatic wait_done(output int dur);
      dur = 0;
      while (complete_oe !== 1'b1) begin
         @(posedge clock);
      end
      while (complete_oe === 1'b1) begin
         @(posedge clock);
         dur++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals();
      rd(ADDR_AXIS, RST_AXIS, RESP_OKAY);
      rd(8'h20, RST_ACCEL, RESP_OKAY);
      rd(8'h44, RST_BASE, RESP_OKAY);
      rd(8'h1c, 0, RESP_SLVERR);
      `CHK("idle reduce", 1'b1, cur_reduce)
      `CHK("idle running", 1'b0, running)
      wr(ADDR_AXIS, AXIS_MAX, RESP_OKAY);
      wr(ADDR_AXIS, AXIS_MAX + 1, RESP_OKAY);
      rd(ADDR_AXIS, AXIS_MAX, RESP_OKAY);
   endtask
   // profile 2 fields: out-of-range values are dropped, upper limits are kept
   task automatic t_ranges();
      int lo [5] = '{99, 0, 0, 'h800000, 0};
      int hi [5] = '{10000000, 5001, 50001, 'h800000, 1001};
      int rv [5] = '{100, 1, 1, 0, 1};
      int gd [5] = '{9999999, 5000, 50000, 8388607, 1000};
      logic [7:0] a;
      for (int i = 0; i < 5; i++) begin
         a = 8'h40 + 8'(4 * i);
         wr(a, lo[i], RESP_OKAY);
         wr(a, hi[i], RESP_OKAY);
         rd(a, rv[i], RESP_OKAY);
         wr(a, gd[i], RESP_OKAY);
         rd(a, gd[i], RESP_OKAY);
      end
      rd(8'h20, RST_ACCEL, RESP_OKAY);
   endtask
   task automatic t_pin_start();
      int s0, t0, d;
      wr(8'h20, 9999999, RESP_OKAY);
      wr(8'h24, 5000, RESP_OKAY);
      wr(8'h28, 10000, RESP_OKAY);
      wr(8'h2c, 3, RESP_OKAY);
      wr(8'h30, 2, RESP_OKAY);
      u_plc.set_pin(0, 1'b0);
      `CHK("pin ccw", 1'b1, dir_ccw)
      s0 = step_cnt;
      t0 = cyc;
      u_plc.press(1);
      wait_steps(s0 + 1);
      `CHK("start at base", 1'b1, cyc - t0 inside {[3995:4015]})
      `CHK("running", 1'b1, running)
      u_plc.press(2);
      wait_done(d);
      `CHK("step count", s0 + 3, step_cnt)
      `CHK("complete time", 2 * CYC_PER_US, d)
      `CHK("pin dir kept", 1'b1, dir_ccw)
   endtask
   task automatic t_sw_go();
      int s0, d;
      wr(8'h4c, 0, RESP_OKAY);
      wr(8'h50, 1, RESP_OKAY);
      s0 = step_cnt;
      wr(ADDR_CTRL, 'h3, RESP_OKAY);
      wait_done(d);
      `CHK("zero count", s0, step_cnt)
      `CHK("complete time", CYC_PER_US, d)
      `CHK("sw dir cw", 1'b0, dir_ccw)
   endtask
   task automatic t_dir_onoff();
      u_plc.set_pin(0, 1'b1);
      `CHK("pin cw", 1'b0, dir_ccw)
      u_plc.set_pin(0, 1'b0);
      `CHK("pin ccw", 1'b1, dir_ccw)
      u_plc.set_pin(1, 1'b0);
      `CHK("phases off", 1'b0, phase_en)
      u_plc.set_pin(1, 1'b1);
      `CHK("phases on", 1'b1, phase_en)
   endtask
   task automatic t_limit(input int which, input int cnt, input int exp);
      int s0, d;
      wr(8'h2c, cnt, RESP_OKAY);
      s0 = step_cnt;
      u_plc.press(1);
      wait_steps(s0 + 2);
      u_plc.set_pin(which, 1'b0);
      wait_done(d);
      `CHK("limit steps", s0 + exp, step_cnt)
      if (which == 2) begin
         `CHK("end at base", 1'b1, last_t - prev_t inside {[3990:4010]})
      end
      u_plc.set_pin(which, 1'b1);
   endtask
   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset_vals();
      t_ranges();
      t_pin_start();
      t_sw_go();
      t_dir_onoff();
      t_limit(3, 100, 2);
      t_limit(2, 6, 6);
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      close_out();
   end
endmodule // test_two_profile_step_indexer
`default_nettype wire
